//--- hw/wsg_pkg.sv
// Shared constants, register map and types for the watchdog and safe-monitor pin block
package wsg_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_TIMING    = 8'h04;
	localparam logic [7:0] OFS_KEY       = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0C;
	localparam logic [7:0] OFS_ALERT     = 8'h10;
	localparam logic [7:0] OFS_PIN_CFG   = 8'h14;
	localparam logic [7:0] OFS_PIN_STAT  = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_SWW_BIT    = 1;
	localparam int CTRL_ALEN_BIT   = 2;
	localparam int CTRL_CPA_BIT    = 3;
	localparam int CTRL_TOPO_LSB   = 4;
	localparam int TIM_DIV_LSB     = 0;
	localparam int TIM_OPN_LSB     = 8;
	localparam int TIM_CLO_LSB     = 12;
	localparam int TIM_FIRST_LSB   = 16;
	localparam int TIM_DBNC_LSB    = 24;
	localparam int ALERT_WDG_BIT   = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  KEY_RST      = 8'h5A;
	localparam logic [31:0] TIMING_RST   = 32'h0100_0000;
	localparam logic [15:0] PIN_CFG_RST  = 16'h0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int TICK_TIME_US   = 256;
	localparam int TICK_CYCLES    = TICK_TIME_US * CLK_MHZ;
	localparam int ONESHOT_MS     = 100;
	localparam int ONESHOT_CYCLES = ONESHOT_MS * 1000 * CLK_MHZ;

	// ----------------------------------------------------------------
	// Pin function codes
	// ----------------------------------------------------------------
	localparam logic [3:0] PIN_GP_IN    = 4'h0;
	localparam logic [3:0] PIN_GP_HI    = 4'h1;
	localparam logic [3:0] PIN_GP_LO    = 4'h2;
	localparam logic [3:0] PIN_SHOT_HI  = 4'h3;
	localparam logic [3:0] PIN_SHOT_LO  = 4'h4;
	localparam logic [3:0] PIN_ACT_HI   = 4'h5;
	localparam logic [3:0] PIN_ACT_LO   = 4'h6;
	localparam logic [3:0] PIN_SLAVE_IN = 4'h7;
	// Legal code masks per pin, bit n set when code n is offered
	localparam logic [31:0] PIN_LEGAL = 32'hFF7F_6767;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		WSG_OFF    = 3'b001,
		WSG_CLOSED = 3'b010,
		WSG_OPEN   = 3'b100
	} wsg_wd_state_t;

	typedef struct packed {
		logic [1:0] topology;
		logic       contactor_pins_on_alert;
		logic       wdg_alert_enable;
		logic       simple_window_select;
		logic       watchdog_enable_bit;
	} wsg_ctrl_t;

	typedef struct packed {
		logic [7:0] timeout_debounce_limit;
		logic [2:0] first_ext;
		logic [3:0] close_len;
		logic [3:0] open_len;
		logic [4:0] wdg_clock_divider;
	} wsg_timing_t;

	localparam wsg_ctrl_t CTRL_RST = '{topology: 2'h0, contactor_pins_on_alert: 1'b0,
		wdg_alert_enable: 1'b1, simple_window_select: 1'b0, watchdog_enable_bit: 1'b0};

	// Next challenge response: shift left, feedback of bits 7,5,2,1
	function automatic logic [7:0] lfsr_next(input logic [7:0] k);
		lfsr_next = {k[6:0], k[7] ^ k[5] ^ k[2] ^ k[1]};
	endfunction : lfsr_next

endpackage : wsg_pkg

//--- hw/wsg_watchdog_gpio.sv
// Host watchdog with safe-monitor pin control behind an APB slave
`timescale 1ns/1ns
module wsg_watchdog_gpio #(
	parameter int TICK_CYCLES    = wsg_pkg::TICK_CYCLES,
	parameter int ONESHOT_CYCLES = wsg_pkg::ONESHOT_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Device state
	input  wire logic        sleep_mode,
	output logic             safe_monitor_state,
	output logic             alert_pin,
	// General pins, index 0 is io_pin_one
	input  wire logic [3:0]  pin_in,
	output logic      [3:0]  pin_out,
	output logic      [3:0]  pin_oe
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	wsg_pkg::wsg_ctrl_t     ctrl_ff;
	wsg_pkg::wsg_timing_t   timing_ff;
	wsg_pkg::wsg_wd_state_t wd_state_ff;
	logic [7:0]             refresh_key_ff;
	logic [7:0]             timeout_tally_ff;
	logic                   window_expired_flag_ff;
	logic                   timeout_limit_flag_ff;
	logic                   bad_key_flag_ff;
	logic                   early_key_flag_ff;
	logic                   wdg_alert_flag_ff;
	logic                   safe_monitor_state_ff;
	logic                   safe_monitor_state_d_ff;
	logic                   first_win_ff;
	logic [15:0]            pin_cfg_ff;
	logic [3:0]             pin_rd_ff;
	logic [3:0]             pin_err_ff;
	logic [3:0]             pin_out_ff;
	logic [3:0]             pin_oe_ff;
	logic [31:0]            prdata_ff;
	logic                   pready_ff;
	logic                   pslverr_ff;
	logic [15:0]            base_cnt_ff;
	logic [4:0]             div_cnt_ff;
	logic [11:0]            phase_cnt_ff;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup_rd;
	logic wr_go;
	logic addr_ok;
	logic wr_ctrl;
	logic wr_key;
	logic en_clear;

	assign setup_rd = psel & ~penable;
	assign wr_go    = psel & penable & pready_ff & pwrite;
	assign addr_ok  = (paddr == wsg_pkg::OFS_CTRL) | (paddr == wsg_pkg::OFS_TIMING) |
	                  (paddr == wsg_pkg::OFS_KEY) | (paddr == wsg_pkg::OFS_STATUS) |
	                  (paddr == wsg_pkg::OFS_ALERT) | (paddr == wsg_pkg::OFS_PIN_CFG) |
	                  (paddr == wsg_pkg::OFS_PIN_STAT);
	assign wr_ctrl  = wr_go & (paddr == wsg_pkg::OFS_CTRL);
	assign wr_key   = wr_go & (paddr == wsg_pkg::OFS_KEY);
	assign en_clear = wr_ctrl & ~pwdata[wsg_pkg::CTRL_EN_BIT];

	// ----------------------------------------------------------------
	// Watchdog tick and window lengths
	// ----------------------------------------------------------------
	logic        base_wrap;
	logic        tick;
	logic [11:0] closed_len;
	logic [11:0] open_len;
	logic [11:0] twd2_len;
	logic [11:0] first_len;
	logic [11:0] open_limit;
	logic        wd_run;

	assign wd_run     = ctrl_ff.watchdog_enable_bit & ~sleep_mode;
	assign base_wrap  = base_cnt_ff == 16'(TICK_CYCLES - 1);
	assign tick       = base_wrap & (div_cnt_ff == timing_ff.wdg_clock_divider);
	assign closed_len = {4'h0, ({1'b0, timing_ff.open_len} + 5'h01), 3'h0};
	assign open_len   = {4'h0, ({1'b0, timing_ff.close_len} + 5'h01), 3'h0};
	assign twd2_len   = closed_len + open_len;
	assign first_len  = 12'(open_len + twd2_len * ({1'b0, timing_ff.first_ext} + 4'h1));
	assign open_limit = first_win_ff ? first_len : open_len;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_cnt_ff <= 16'h0000;
			div_cnt_ff  <= 5'h00;
		end else if (!wd_run) begin
			base_cnt_ff <= 16'h0000;
			div_cnt_ff  <= 5'h00;
		end else if (base_wrap) begin
			base_cnt_ff <= 16'h0000;
			div_cnt_ff  <= tick ? 5'h00 : div_cnt_ff + 5'h01;
		end else begin
			base_cnt_ff <= base_cnt_ff + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Key qualification
	// ----------------------------------------------------------------
	logic key_match;
	logic key_valid;
	logic in_open;
	logic in_closed;
	logic refresh;
	logic sm_release;
	logic timeout;
	logic limit_hit;
	logic set_bad;
	logic set_early;

	assign key_match  = pwdata[7:0] == wsg_pkg::lfsr_next(refresh_key_ff);
	assign key_valid  = ctrl_ff.simple_window_select | key_match;
	assign in_open    = wd_state_ff == wsg_pkg::WSG_OPEN;
	assign in_closed  = wd_state_ff == wsg_pkg::WSG_CLOSED;
	// In safe-monitor the window is ignored: only the key content counts
	assign sm_release = wr_key & safe_monitor_state_ff & key_valid;
	assign refresh    = (wr_key & ~safe_monitor_state_ff & in_open & key_valid) | sm_release;
	assign timeout    = in_open & ~safe_monitor_state_ff & tick & (phase_cnt_ff == open_limit - 12'h001);
	assign limit_hit  = timeout & ((timeout_tally_ff + 8'h01) >= timing_ff.timeout_debounce_limit);
	assign set_bad    = wr_key & ~safe_monitor_state_ff & in_open & ~ctrl_ff.simple_window_select & ~key_match;
	assign set_early  = wr_key & ~safe_monitor_state_ff & in_closed & ~ctrl_ff.simple_window_select;

	// ----------------------------------------------------------------
	// Window state machine
	// ----------------------------------------------------------------
	wsg_pkg::wsg_wd_state_t nxt_wd_state;

	always_comb begin
		nxt_wd_state = wd_state_ff;
		case (wd_state_ff)
			wsg_pkg::WSG_OFF: begin
				if (wd_run)
					nxt_wd_state = wsg_pkg::WSG_OPEN;
			end
			wsg_pkg::WSG_CLOSED: begin
				if (!wd_run)
					nxt_wd_state = wsg_pkg::WSG_OFF;
				else if (sm_release)
					nxt_wd_state = wsg_pkg::WSG_OPEN;
				else if (tick && phase_cnt_ff == closed_len - 12'h001 && !safe_monitor_state_ff)
					nxt_wd_state = wsg_pkg::WSG_OPEN;
			end
			wsg_pkg::WSG_OPEN: begin
				if (!wd_run)
					nxt_wd_state = wsg_pkg::WSG_OFF;
				else if (sm_release)
					nxt_wd_state = wsg_pkg::WSG_OPEN;
				else if (refresh || timeout)
					nxt_wd_state = wsg_pkg::WSG_CLOSED;
			end
			default: nxt_wd_state = wsg_pkg::WSG_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_state_ff  <= wsg_pkg::WSG_OFF;
			phase_cnt_ff <= 12'h000;
			first_win_ff <= 1'b1;
		end else begin
			wd_state_ff <= nxt_wd_state;
			if (nxt_wd_state != wd_state_ff || sm_release || !wd_run)
				phase_cnt_ff <= 12'h000;
			else if (tick && !safe_monitor_state_ff)
				phase_cnt_ff <= phase_cnt_ff + 12'h001;
			if (wd_state_ff == wsg_pkg::WSG_OFF || sm_release)
				first_win_ff <= 1'b1;
			else if (refresh || timeout)
				first_win_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Key, tally and safe-monitor state
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_key_ff   <= wsg_pkg::KEY_RST;
			timeout_tally_ff <= 8'h00;
			safe_monitor_state_ff       <= 1'b0;
			safe_monitor_state_d_ff     <= 1'b0;
		end else begin
			safe_monitor_state_d_ff <= safe_monitor_state_ff;
			if (refresh && !ctrl_ff.simple_window_select)
				refresh_key_ff <= wsg_pkg::lfsr_next(refresh_key_ff);
			if (refresh || en_clear)
				timeout_tally_ff <= 8'h00;
			else if (timeout && timeout_tally_ff != 8'hFF)
				timeout_tally_ff <= timeout_tally_ff + 8'h01;
			if (sm_release)
				safe_monitor_state_ff <= 1'b0;
			else if (limit_hit)
				safe_monitor_state_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Error flags; a set in the clearing cycle wins
	// ----------------------------------------------------------------
	logic any_err_set;

	assign any_err_set = timeout | limit_hit | set_bad | set_early;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window_expired_flag_ff <= 1'b0;
			timeout_limit_flag_ff  <= 1'b0;
			bad_key_flag_ff        <= 1'b0;
			early_key_flag_ff      <= 1'b0;
		end else begin
			window_expired_flag_ff <= timeout | (window_expired_flag_ff & ~en_clear);
			timeout_limit_flag_ff  <= limit_hit | (timeout_limit_flag_ff & ~en_clear);
			bad_key_flag_ff        <= set_bad | (bad_key_flag_ff & ~en_clear);
			early_key_flag_ff      <= set_early | (early_key_flag_ff & ~en_clear);
		end
	end

	// Alert clears only by writing zero; writing one has no effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wdg_alert_flag_ff <= 1'b0;
		else if (any_err_set && ctrl_ff.wdg_alert_enable)
			wdg_alert_flag_ff <= 1'b1;
		else if (wr_go && paddr == wsg_pkg::OFS_ALERT && !pwdata[wsg_pkg::ALERT_WDG_BIT])
			wdg_alert_flag_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff    <= wsg_pkg::CTRL_RST;
			timing_ff  <= {wsg_pkg::TIMING_RST[31:24], wsg_pkg::TIMING_RST[18:16], wsg_pkg::TIMING_RST[15:12],
			               wsg_pkg::TIMING_RST[11:8], wsg_pkg::TIMING_RST[4:0]};
			pin_cfg_ff <= wsg_pkg::PIN_CFG_RST;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= wsg_pkg::wsg_ctrl_t'(pwdata[5:0]);
			if (wr_go && paddr == wsg_pkg::OFS_TIMING)
				timing_ff <= {pwdata[31:24], pwdata[18:16], pwdata[15:12], pwdata[11:8], pwdata[4:0]};
			if (wr_go && paddr == wsg_pkg::OFS_PIN_CFG)
				pin_cfg_ff <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers, one per pin
	// ----------------------------------------------------------------
	logic sm_entry;
	logic sm_drive;

	assign sm_entry = safe_monitor_state_ff & ~safe_monitor_state_d_ff;
	// Safe-monitor outputs idle when not monitoring, including sleep
	assign sm_drive = safe_monitor_state_ff & ~sleep_mode;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			logic [3:0]  code;
			logic        legal;
			logic        act;
			logic [26:0] shot_cnt_ff;
			logic        shot;
			logic        nxt_out;
			logic        nxt_oe;

			assign code  = pin_cfg_ff[4*gi +: 4];
			assign legal = ~code[3] & wsg_pkg::PIN_LEGAL[8*gi + 32'(code[2:0])];
			if (gi < 2) begin : g_cpa
				assign act = sm_drive | (ctrl_ff.contactor_pins_on_alert & wdg_alert_flag_ff);
			end else begin : g_plain
				assign act = sm_drive;
			end
			assign shot = shot_cnt_ff != 27'h0;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					shot_cnt_ff <= 27'h0;
				else if (sm_entry)
					shot_cnt_ff <= 27'(ONESHOT_CYCLES);
				else if (shot)
					shot_cnt_ff <= shot_cnt_ff - 27'h1;
			end

			always_comb begin
				nxt_out = 1'b0;
				nxt_oe  = 1'b0;
				if (legal) begin
					case (code)
						wsg_pkg::PIN_GP_HI: begin
							nxt_oe  = 1'b1;
							nxt_out = 1'b1;
						end
						wsg_pkg::PIN_GP_LO: begin
							nxt_oe  = 1'b1;
							nxt_out = 1'b0;
						end
						wsg_pkg::PIN_SHOT_HI: begin
							nxt_oe  = 1'b1;
							nxt_out = shot & sm_drive;
						end
						wsg_pkg::PIN_SHOT_LO: begin
							nxt_oe  = 1'b1;
							nxt_out = ~(shot & sm_drive);
						end
						wsg_pkg::PIN_ACT_HI: begin
							nxt_oe  = 1'b1;
							nxt_out = act;
						end
						wsg_pkg::PIN_ACT_LO: begin
							nxt_oe  = 1'b1;
							nxt_out = ~act;
						end
						default: begin
							nxt_oe  = 1'b0;
							nxt_out = 1'b0;
						end
					endcase
				end
			end

			// Reserved codes fall through with the enable low
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_out_ff[gi] <= 1'b0;
					pin_oe_ff[gi]  <= 1'b0;
					pin_rd_ff[gi]  <= 1'b0;
					pin_err_ff[gi] <= 1'b0;
				end else begin
					pin_out_ff[gi] <= nxt_out;
					pin_oe_ff[gi]  <= nxt_oe;
					pin_rd_ff[gi]  <= pin_in[gi];
					pin_err_ff[gi] <= pin_oe_ff[gi] & (pin_in[gi] != pin_out_ff[gi]);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// APB read path; ready a cycle after setup, so no wait states
	// ----------------------------------------------------------------
	logic [31:0] nxt_prdata;

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		case (paddr)
			wsg_pkg::OFS_CTRL:     nxt_prdata = {26'h0, ctrl_ff};
			wsg_pkg::OFS_TIMING:   nxt_prdata = {timing_ff.timeout_debounce_limit, 5'h00, timing_ff.first_ext,
			                                     timing_ff.close_len, timing_ff.open_len, 3'h0,
			                                     timing_ff.wdg_clock_divider};
			wsg_pkg::OFS_KEY:      nxt_prdata = {24'h0, refresh_key_ff};
			wsg_pkg::OFS_STATUS:   nxt_prdata = {16'h0, wd_state_ff, safe_monitor_state_ff, early_key_flag_ff,
			                                     bad_key_flag_ff, timeout_limit_flag_ff,
			                                     window_expired_flag_ff, 8'h00} | {24'h0, timeout_tally_ff};
			wsg_pkg::OFS_ALERT:    nxt_prdata = {31'h0, wdg_alert_flag_ff};
			wsg_pkg::OFS_PIN_CFG:  nxt_prdata = {16'h0, pin_cfg_ff};
			wsg_pkg::OFS_PIN_STAT: nxt_prdata = {24'h0, pin_err_ff, pin_rd_ff};
			default:               nxt_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= setup_rd;
			pslverr_ff <= setup_rd & ~addr_ok;
			if (setup_rd && !pwrite)
				prdata_ff <= nxt_prdata;
		end
	end

	assign prdata             = prdata_ff;
	assign pready             = pready_ff;
	assign pslverr            = pslverr_ff;
	assign safe_monitor_state = safe_monitor_state_ff;
	assign alert_pin          = wdg_alert_flag_ff;
	assign pin_out            = pin_out_ff;
	assign pin_oe             = pin_oe_ff;

endmodule : wsg_watchdog_gpio

//--- verif/wsg_pin_partner.sv
// Wire-level model of the four general pins and whatever drives them from outside
`timescale 1ns/1ns
module wsg_pin_partner (
	// Device side
	input  wire logic [3:0]	pin_out,
	input  wire logic [3:0]	pin_oe,
	// Outside drivers
	input  wire logic [3:0]	ext_val,
	input  wire logic [3:0]	ext_en,
	// Sensed level
	output logic [3:0]	pin_in
);
	// An outside driver overpowers the device so that contention can be provoked
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else
				pin_in[i] = 1'b0;
		end
	end
endmodule : wsg_pin_partner

//--- verif/wsg_watchdog_gpio_assertions.sv
// Port checker for the watchdog and safe-monitor pin block
`timescale 1ns/1ns
module wsg_wdg_checker #(
	parameter int TICK_CYCLES	= 4,
	parameter int ONESHOT_CYCLES	= 20
) (
	// Clock and reset
	input wire logic	pclk,
	input wire logic	presetn,
	// APB
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	// State and pins
	input wire logic	sleep_mode,
	input wire logic	safe_monitor_state,
	input wire logic	alert_pin,
	input wire logic [3:0]	pin_in,
	input wire logic [3:0]	pin_out,
	input wire logic [3:0]	pin_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0]	cfg_ff;
	logic		alen_ff;
	logic [31:0]	shot_ff;
	logic [3:0]	legal, fix_m, fix_hi, act_m, act_lo;
	logic		wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			legal[i] = !cfg_ff[4*i+3] && wsg_pkg::PIN_LEGAL[8*i+cfg_ff[4*i+:3]];
			fix_hi[i] = cfg_ff[4*i+:4] == wsg_pkg::PIN_GP_HI;
			fix_m[i] = fix_hi[i] || cfg_ff[4*i+:4] == wsg_pkg::PIN_GP_LO;
			act_lo[i] = cfg_ff[4*i+:4] == wsg_pkg::PIN_ACT_LO;
			act_m[i] = act_lo[i] || cfg_ff[4*i+:4] == wsg_pkg::PIN_ACT_HI;
		end
	end
	// Shadow of the pin setup, so pin expectations follow what software wrote
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg_ff <= wsg_pkg::PIN_CFG_RST;
		else if (wr_done && paddr == wsg_pkg::OFS_PIN_CFG)
			cfg_ff <= pwdata[15:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			alen_ff <= wsg_pkg::CTRL_RST.wdg_alert_enable;
		else if (wr_done && paddr == wsg_pkg::OFS_CTRL)
			alen_ff <= pwdata[wsg_pkg::CTRL_ALEN_BIT];
	end
	// Pulse length is counted here, too long for a repetition operator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			shot_ff <= '0;
		else if (cfg_ff[11:8] == wsg_pkg::PIN_SHOT_HI && pin_oe[2] && pin_out[2])
			shot_ff <= shot_ff + 32'h1;
		else
			shot_ff <= '0;
	end
	sequence s_setup; psel && !penable; endsequence
	sequence s_reply; pready ##1 !pready; endsequence
	property p_apb_ready; s_setup |=> s_reply; endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("pready not one cycle after setup");
	property p_apb_err; pready |-> pslverr == (paddr > 8'h18 || paddr[1:0] != 2'b00); endproperty
	a_apb_err: assert property (p_apb_err) else $error("pslverr wrong for address");
	property p_alert_hold; alert_pin && !(wr_done && paddr == wsg_pkg::OFS_ALERT && !pwdata[0]) |=> alert_pin; endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("alert dropped without clear");
	property p_alert_rise; $rose(alert_pin) |-> $past(alen_ff); endproperty
	a_alert_rise: assert property (p_alert_rise) else $error("alert raised while disabled");
	property p_reserved; $stable(cfg_ff) |-> (pin_oe & ~legal) == 4'h0; endproperty
	a_reserved: assert property (p_reserved) else $error("reserved pin code drives");
	property p_fixed; $stable(cfg_ff) |-> (pin_oe & fix_m) == fix_m && (pin_out & fix_m) == fix_hi; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed pin level lost");
	property p_idle;
		!safe_monitor_state && !$past(safe_monitor_state) && !alert_pin && !$past(alert_pin) && $stable(cfg_ff)
			|-> ((pin_out ^ act_lo) & pin_oe & act_m) == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("active pin not idle");
	property p_shot_len; shot_ff <= ONESHOT_CYCLES; endproperty
	a_shot_len: assert property (p_shot_len) else $error("one-shot pulse too long");
endmodule : wsg_wdg_checker
bind wsg_watchdog_gpio wsg_wdg_checker #(.TICK_CYCLES(TICK_CYCLES), .ONESHOT_CYCLES(ONESHOT_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
	.safe_monitor_state(safe_monitor_state), .alert_pin(alert_pin), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe(pin_oe));

//--- verif/test_watchdog_safe_monitor_state_gpio.sv
// Self-checking bench for the watchdog and safe-monitor pin block
`timescale 1ns/1ns
module test_watchdog_safe_monitor_state_gpio;
	localparam int SHOT = 20;
	logic		pclk, presetn, psel, penable, pwrite, sleep_mode, pready, pslverr, safe_st, alert, e;
	logic [7:0]	paddr, key;
	logic [31:0]	pwdata, prdata, r;
	logic [3:0]	pin_in, pin_out, pin_oe, ext_val, ext_en;
	int		fails = 0, checks = 0, shot_hi = 0, shot_lo = 0;
	logic [7:0]	ra [5] = '{wsg_pkg::OFS_CTRL, wsg_pkg::OFS_TIMING, wsg_pkg::OFS_KEY, wsg_pkg::OFS_PIN_CFG, 8'h1C};
	logic [31:0]	rv [5] = '{32'h4, wsg_pkg::TIMING_RST, {24'h0, wsg_pkg::KEY_RST}, 32'h0, 32'h0};
	wsg_watchdog_gpio #(.TICK_CYCLES(4), .ONESHOT_CYCLES(SHOT)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_mode(sleep_mode), .safe_monitor_state(safe_st), .alert_pin(alert),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	wsg_pin_partner u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (pin_oe[2] && pin_out[2]) shot_hi++;
		if (pin_oe[3] && !pin_out[3]) shot_lo++;
	end
	function automatic logic [7:0] nxt(input logic [7:0] k);
		return {k[6:0], k[7] ^ k[5] ^ k[2] ^ k[1]};
	endfunction : nxt
	// Pin one fixed high, pin two reserved, both driven from outside
	function automatic logic [7:0] pins_exp(input logic [3:0] v);
		return {2'b00, 1'b0, ~v[0], 2'b00, v[1:0]};
	endfunction : pins_exp
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One APB transfer; an edge always passes first so psel is never set twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk("pready", pready, 1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		repeat (30000) @(posedge pclk);
		fails++;
		end_sim();
	end
	initial begin
		{psel, penable, pwrite, sleep_mode, presetn} = '0;
		{paddr, pwdata, ext_val, ext_en} = '0;
		key = wsg_pkg::KEY_RST;
		void'($urandom(46510));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) begin
			apb(0, ra[i], 0);
			chk("reset value", r, rv[i]);
			chk("slave error", e, ra[i] == 8'h1C);
		end
		apb(1, wsg_pkg::OFS_PIN_CFG, 32'h4331);
		apb(1, wsg_pkg::OFS_TIMING, 32'h0200_0000);
		apb(1, wsg_pkg::OFS_CTRL, 32'h5);
		apb(0, wsg_pkg::OFS_KEY, 0);
		chk("key", r, {24'h0, key});
		apb(1, wsg_pkg::OFS_KEY, {24'h0, nxt(key)});
		key = nxt(key);
		apb(0, wsg_pkg::OFS_KEY, 0);
		chk("advanced key", r, {24'h0, key});
		apb(1, wsg_pkg::OFS_KEY, {24'h0, nxt(key)});
		apb(0, wsg_pkg::OFS_STATUS, 0);
		chk("early flag", r[11:0], 12'h800);
		chk("alert pin", alert, 1);
		apb(1, wsg_pkg::OFS_ALERT, 0);
		repeat (1) @(posedge pclk);
		chk("alert released", alert, 0);
		repeat (30) @(posedge pclk);
		apb(1, wsg_pkg::OFS_KEY, {24'h0, ~nxt(key)});
		apb(0, wsg_pkg::OFS_STATUS, 0);
		chk("bad key flag", r[11:8], 4'hC);
		repeat (150) @(posedge pclk);
		apb(0, wsg_pkg::OFS_STATUS, 0);
		chk("timeouts", r[12:0], 13'h1F02);
		chk("safe state", safe_st, 1);
		chk("high shot", shot_hi, SHOT);
		chk("low shot", shot_lo, SHOT);
		apb(1, wsg_pkg::OFS_KEY, {24'h0, nxt(key)});
		key = nxt(key);
		apb(0, wsg_pkg::OFS_STATUS, 0);
		chk("recovered", {safe_st, r[7:0]}, 9'h0);
		apb(1, wsg_pkg::OFS_CTRL, 32'h4);
		apb(0, wsg_pkg::OFS_STATUS, 0);
		chk("disabled status", r[15:0], 16'h2000);
		// Divider one halves the tick rate, so only one window expires before the read
		apb(1, wsg_pkg::OFS_TIMING, 32'h0200_0001);
		apb(1, wsg_pkg::OFS_CTRL, 32'h7);
		apb(1, wsg_pkg::OFS_KEY, $urandom);
		apb(1, wsg_pkg::OFS_KEY, $urandom);
		repeat (150) @(posedge pclk);
		apb(0, wsg_pkg::OFS_STATUS, 0);
		chk("simple window", r[11:0], 12'h101);
		apb(0, wsg_pkg::OFS_KEY, 0);
		chk("simple key", r, {24'h0, key});
		apb(1, wsg_pkg::OFS_CTRL, 32'h4);
		repeat (6) begin
			ext_en <= 4'b0011;
			ext_val <= 4'($urandom);
			sleep_mode <= 1'($urandom);
			repeat (3) @(posedge pclk);
			apb(0, wsg_pkg::OFS_PIN_STAT, 0);
			chk("pin status", r[7:0] & 8'h33, pins_exp(ext_val));
		end
		// Dual-link master setup; contactor pins follow the alert still pending
		apb(1, wsg_pkg::OFS_CTRL, 32'h3C);
		apb(1, wsg_pkg::OFS_PIN_CFG, 32'h7565);
		repeat (2) @(posedge pclk);
		chk("contactor pins", {pin_oe, pin_out}, 8'h71);
		apb(1, wsg_pkg::OFS_ALERT, 0);
		repeat (2) @(posedge pclk);
		chk("idle pins", {pin_oe, pin_out}, 8'h72);
		sleep_mode <= 1'b0;
		apb(1, wsg_pkg::OFS_CTRL, 32'h1);
		apb(1, wsg_pkg::OFS_KEY, {24'h0, ~nxt(key)});
		apb(0, wsg_pkg::OFS_STATUS, 0);
		chk("masked alert", {alert, r[10]}, 2'b01);
		end_sim();
	end
endmodule : test_watchdog_safe_monitor_state_gpio
